/* File: flash_status_lock_suspend_bench.sv */
// self-checking bench: apb master, flash model, queued answer checks
`timescale 1ns/1ps
`include "fsl_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module flash_status_lock_suspend_bench import fsl_pkg::*; ;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rdv, prdata;
   logic pready, pslverr, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_ready;
   logic [19:0] fl_addr, a;
   logic [15:0] fl_dq_out, fl_dq_in;
   logic [7:0] d;
   logic [1:0] fault = 2'b00; // injected failure kind
   logic mode01 = 1'b0; // flash model in status config 01
   logic [32:0] exp_q[$], msk_q[$], e, m; // notes {pslverr, prdata} and masks
   int n_errors = 0, comparisons = 0, seed = 37;
   always #2.5 clk = ~clk;
   fsl_ctrl fsl_ctrl_i (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_dq_in, .fl_ce_n, .fl_oe_n,
      .fl_we_n, .fl_reset_n, .fl_ready);
   fsl_flash_model fsl_flash_model_i (.addr(fl_addr), .dq_out(fl_dq_out), .dq_oe(fl_dq_oe),
      .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .reset_n(fl_reset_n), .fault(fault),
      .mode01(mode01), .dq_in(fl_dq_in), .ready(fl_ready));
   // verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // one apb transfer; the note goes in before the request
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
      input logic [32:0] ex, input logic [32:0] mk);
      int n;
      exp_q.push_back(ex);
      msk_q.push_back(mk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk) penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      rdv = prdata;
      if (n >= 20) begin n_errors++; end_of_test(); end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      apb(1'b1, ad, wd, 33'h0, 33'h1_0000_0000);
   endtask : wr
   task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] mk);
      apb(1'b0, ad, 32'h0, {1'b0, ex}, {1'b1, mk});
   endtask : rd
   // status reads until busy clears; the notes of these reads are fully masked
   task automatic wait_idle();
      int n;
      n = 0;
      do begin apb(1'b0, `FSL_REG_STATUS, 32'h0, 33'h0, 33'h0); n++; end
      while (rdv[0] !== 1'b0 && n < 2000); // bound covers the full suspend wait
      if (n >= 2000) begin n_errors++; end_of_test(); end
   endtask : wait_idle
   // program one word, poll it to its end, then check its status
   task automatic prog(input logic [1:0] f, input logic [31:0] st, input logic [31:0] sm);
      fault <= f;
      wr(`FSL_REG_SEQ, {4'h0, a, d});
      wr(`FSL_REG_ADDR, {12'h000, a});
      wr(`FSL_REG_CTRL, {25'h0, 3'd1, `FSL_OP_SEQ});
      wait_idle();
      wr(`FSL_REG_CTRL, {28'h0, `FSL_OP_POLL});
      wait_idle();
      rd(`FSL_REG_STATUS, st, sm);
      fault <= 2'b00;
   endtask : prog
   // answer watcher: oldest note against each completed transfer
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         `CHK("apb answer", e & m, {pslverr, prdata} & m)
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(`FSL_REG_CFG, 32'h0, 32'hFFFF_FFFF);
      rd(`FSL_REG_STATUS, 32'h100, 32'h1FF);
      apb(1'b0, 8'h30, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
      wr(`FSL_REG_EXIT, {4'h0, 20'h00555, 8'hF0});
      $display("test defaults done");
      for (int i = 0; i < 3; i++) begin
         a = 20'($random(seed));
         d = 8'($random(seed));
         prog(2'b00, 32'h02, 32'h1F);
         wr(`FSL_REG_CTRL, {28'h0, `FSL_OP_READ});
         wait_idle();
         rd(`FSL_REG_RDATA, {24'h0, d}, 32'hFF);
      end
      $display("test program done");
      for (int f = 1; f < 3; f++) begin
         prog(2'(f), (f == 1) ? 32'h14 : 32'h0C, 32'h1C);
         d = ~d;
         prog(2'b00, 32'h02, 32'h1F);
         wr(`FSL_REG_CTRL, {28'h0, `FSL_OP_READ});
         wait_idle();
         rd(`FSL_REG_RDATA, {24'h0, d}, 32'hFF);
      end
      $display("test faults done");
      // the word at offset 2 of the sector carries the lock bit
      a = 20'h00102;
      d = 8'h01;
      prog(2'b00, 32'h02, 32'h1F);
      wr(`FSL_REG_ADDR, 32'h0000_0100);
      wr(`FSL_REG_CTRL, {28'h0, `FSL_OP_LOCKQ});
      wait_idle();
      rd(`FSL_REG_STATUS, 32'h22, 32'h23);
      $display("test lock query done");
      // config 01: bit 7 ends the poll, an exit cycle follows every result
      mode01 <= 1'b1;
      wr(`FSL_REG_CFG, 32'h1);
      for (int f = 1; f >= 0; f--) begin
         d = 8'($random(seed));
         prog(2'(f), (f == 1) ? 32'h56 : 32'h42, 32'h5F);
      end
      wr(`FSL_REG_CTRL, {28'h0, `FSL_OP_READ});
      wait_idle();
      rd(`FSL_REG_RDATA, {24'h0, d}, 32'hFF);
      $display("test config 01 done");
      // suspend: one command cycle, then the full halt time is waited out
      wr(`FSL_REG_SEQ, {4'h0, 20'h00000, 8'h5A});
      wr(`FSL_REG_CTRL, {25'h0, 3'd1, `FSL_OP_SUSP});
      repeat (3000) @(posedge clk);
      rd(`FSL_REG_STATUS, 32'h1, 32'h3);
      wait_idle();
      rd(`FSL_REG_STATUS, 32'h2, 32'h3);
      $display("test suspend done");
      wr(`FSL_REG_CTRL, {28'h0, `FSL_OP_RESET});
      wait_idle();
      rd(`FSL_REG_CFG, 32'h1, 32'h1);
      rd(`FSL_REG_STATUS, 32'h0, 32'h20);
      $display("test reset done");
      end_of_test();
   end
endmodule : flash_status_lock_suspend_bench

/* File: fsl_cfg.svh */
// constants for the flash status, lockdown and suspend controller
`ifndef FSL_CFG_SVH
`define FSL_CFG_SVH
// clock rate and ns-to-cycle rounding (least times round up)
`define FSL_CLK_MHZ 200
`define FSL_CYC(ns) (((ns) * `FSL_CLK_MHZ + 999) / 1000)
// flash bus timing, ns
`define FSL_T_WSU_NS 20
`define FSL_T_WP_NS 40
`define FSL_T_WH_NS 20
`define FSL_T_ACC_NS 70
`define FSL_T_RREC_NS 20
`define FSL_T_RST_NS 500
`define FSL_T_ESUSP_NS 15000
`define FSL_T_PSUSP_NS 20000
// register byte offsets
`define FSL_REG_CTRL 8'h00
`define FSL_REG_ADDR 8'h04
`define FSL_REG_RDATA 8'h08
`define FSL_REG_STATUS 8'h0C
`define FSL_REG_CFG 8'h10
`define FSL_REG_EXIT 8'h14
`define FSL_REG_SEQ 8'h40
// ctrl fields and operation codes
`define FSL_OP_LSB 0
`define FSL_CNT_LSB 4
`define FSL_OP_SEQ 4'h1
`define FSL_OP_READ 4'h2
`define FSL_OP_POLL 4'h3
`define FSL_OP_RESET 4'h4
`define FSL_OP_SUSP 4'h5
`define FSL_OP_LOCKQ 4'h6
// sequence table depth and entry layout {addr[19:0], data[7:0]}
`define FSL_SEQ_DEPTH 6
`define FSL_ENT_DLSB 0
`define FSL_ENT_ALSB 8
// flash data bit positions
`define FSL_BIT_POLL 7
`define FSL_BIT_TOGGLE 6
`define FSL_BIT_OPFAIL 5
`define FSL_BIT_SUPPLY 3
`define FSL_BIT_LOCK 0
// lock-state location inside a sector
`define FSL_LOCK_OFS 20'h00002
`endif

/* File: fsl_ctrl.sv */
// host-side controller driving a parallel nor flash, steered over apb
//
// How it works
// - config 01: send exit after success
// - any failure: send exit before continuing
// - config change is four write cycles
// - bit 3 supply fault needs exit command
// - locks clear at reset; six-cycle lock
// - suspended erase blocks others; resume command
// - address at later fall, data at rise
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`include "fsl_cfg.svh"
module fsl_ctrl import fsl_pkg::*; (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic [19:0] fl_addr,
   output logic [15:0] fl_dq_out,
   output logic fl_dq_oe,
   input wire logic [15:0] fl_dq_in,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   output logic fl_reset_n,
   input wire logic fl_ready
);
   // phase lengths in cycles, minus one for the down-counter
   localparam logic [12:0] WSU = 13'(`FSL_CYC(`FSL_T_WSU_NS) - 1);
   localparam logic [12:0] WP = 13'(`FSL_CYC(`FSL_T_WP_NS) - 1);
   localparam logic [12:0] WH = 13'(`FSL_CYC(`FSL_T_WH_NS) - 1);
   localparam logic [12:0] ACC = 13'(`FSL_CYC(`FSL_T_ACC_NS) - 1);
   localparam logic [12:0] RREC = 13'(`FSL_CYC(`FSL_T_RREC_NS) - 1);
   localparam logic [12:0] RST = 13'(`FSL_CYC(`FSL_T_RST_NS) - 1);
   // suspend wait covers the longer of erase and program halt time
   localparam int SUSP_NS = (`FSL_T_PSUSP_NS > `FSL_T_ESUSP_NS) ?
      `FSL_T_PSUSP_NS : `FSL_T_ESUSP_NS;
   localparam logic [12:0] SUSP = 13'(`FSL_CYC(SUSP_NS) - 1);

   fsl_state_t q; // registered state
   fsl_state_t next_q; // next state
   logic [15:0] cur; // word on the flash data bus this cycle, not registered
   logic acc; // apb access completes this edge
   logic [27:0] ent; // current write-cycle entry

   assign cur = fl_dq_in;
   assign acc = psel & penable & q.pready;
   assign ent = q.in_exit ? q.exitc : q.seq[q.idx];

   // next-state logic: apb slave and flash bus engine
   always_comb begin
      next_q = q;
      // apb: answer in the access phase right after setup, no wait states
      next_q.pready = 1'b0;
      next_q.pslverr = 1'b0;
      if (psel && !penable && !q.pready) begin
         next_q.pready = 1'b1;
         next_q.prdata = 32'h0;
         unique case (paddr)
            `FSL_REG_CTRL: next_q.prdata = {28'h0, q.op};
            `FSL_REG_ADDR: next_q.prdata = {12'h0, q.addr};
            `FSL_REG_RDATA: next_q.prdata = {16'h0, q.rdata};
            `FSL_REG_STATUS: next_q.prdata = {23'h0, fl_ready, 1'b0, q.cfg, q.lock, q.opf,
                                              q.vpp, q.fail, q.done,
                                              (q.st != FSL_IDLE)};
            `FSL_REG_CFG: next_q.prdata = {31'h0, q.cfg};
            `FSL_REG_EXIT: next_q.prdata = {4'h0, q.exitc};
            default: begin
               // sequence table words, anything else is an error
               if (paddr[7:5] == `FSL_REG_SEQ >> 5 && paddr[1:0] == 2'h0 &&
                   paddr[4:2] < 3'(`FSL_SEQ_DEPTH))
                  next_q.prdata = {4'h0, q.seq[paddr[4:2]]};
               else
                  next_q.pslverr = 1'b1;
            end
         endcase
      end
      // apb writes take effect only on the completing edge
      if (acc && pwrite && !q.pslverr) begin
         if (paddr == `FSL_REG_ADDR)
            next_q.addr = pwdata[19:0];
         if (paddr == `FSL_REG_CFG)
            next_q.cfg = pwdata[0];
         if (paddr == `FSL_REG_EXIT)
            next_q.exitc = pwdata[27:0];
         if (paddr[7:5] == `FSL_REG_SEQ >> 5 && paddr[4:2] < 3'(`FSL_SEQ_DEPTH))
            next_q.seq[paddr[4:2]] = pwdata[27:0];
         // a start while busy is dropped; status busy tells software why
         if (paddr == `FSL_REG_CTRL && q.st == FSL_IDLE) begin
            next_q.op = pwdata[`FSL_OP_LSB +: 4];
            next_q.cnt = pwdata[`FSL_CNT_LSB +: 3];
            next_q.idx = 3'h0;
            next_q.done = 1'b0;
            next_q.fail = 1'b0;
            next_q.first = 1'b1;
            next_q.err_seen = 1'b0;
            next_q.in_exit = 1'b0;
            next_q.opf = 1'b0; // only a failing status word raises these
            next_q.vpp = 1'b0;
            unique case (pwdata[`FSL_OP_LSB +: 4])
               // config set (4 cycles), lockdown (6), suspend/resume (1)
               `FSL_OP_SEQ, `FSL_OP_SUSP: begin
                  next_q.st = FSL_WSU;
                  next_q.tmr = WSU;
               end
               `FSL_OP_READ, `FSL_OP_POLL, `FSL_OP_LOCKQ: begin
                  next_q.st = FSL_RACC;
                  next_q.tmr = ACC;
               end
               `FSL_OP_RESET: begin
                  next_q.st = FSL_RST;
                  next_q.tmr = RST;
               end
               default: next_q.done = 1'b1; // unknown op finishes at once
            endcase
         end
      end
      // flash engine timer
      if (q.tmr != 13'h0)
         next_q.tmr = q.tmr - 13'h1;
      unique case (q.st)
         FSL_IDLE: begin
            next_q.ce_n = 1'b1;
            next_q.oe_n = 1'b1;
            next_q.we_n = 1'b1;
            next_q.dq_oe = 1'b0;
            next_q.rst_n = 1'b1;
         end
         // write: address set up with oe high, then we low
         FSL_WSU: begin
            next_q.fa = ent[`FSL_ENT_ALSB +: 20];
            next_q.fd = {8'h00, ent[`FSL_ENT_DLSB +: 8]};
            next_q.dq_oe = 1'b1;
            next_q.oe_n = 1'b1;
            next_q.ce_n = 1'b0;
            if (q.tmr == 13'h0) begin
               next_q.we_n = 1'b0; // address caught at this fall
               next_q.st = FSL_WLOW;
               next_q.tmr = WP;
            end
         end
         FSL_WLOW: begin
            if (q.tmr == 13'h0) begin
               next_q.we_n = 1'b1; // data caught at this rise
               next_q.st = FSL_WHOLD;
               next_q.tmr = WH;
            end
         end
         FSL_WHOLD: begin
            if (q.tmr == 13'h0) begin
               next_q.ce_n = 1'b1;
               next_q.dq_oe = 1'b0;
               if (q.in_exit) begin
                  next_q.st = FSL_IDLE;
                  next_q.done = 1'b1;
               end else if (q.idx + 3'h1 < q.cnt) begin
                  next_q.idx = q.idx + 3'h1;
                  next_q.st = FSL_WSU;
                  next_q.tmr = WSU;
               end else if (q.op == `FSL_OP_SUSP) begin
                  // halt time is a maximum, so wait it out in full
                  next_q.st = FSL_WAIT;
                  next_q.tmr = SUSP;
               end else begin
                  next_q.st = FSL_IDLE;
                  next_q.done = 1'b1;
               end
            end
         end
         // read: ce and oe low, sample at end of access time
         FSL_RACC: begin
            next_q.fa = (q.op == `FSL_OP_LOCKQ) ? (q.addr | `FSL_LOCK_OFS) : q.addr;
            next_q.dq_oe = 1'b0;
            next_q.ce_n = 1'b0;
            next_q.oe_n = 1'b0;
            if (q.tmr == 13'h0) begin
               next_q.ce_n = 1'b1;
               next_q.oe_n = 1'b1;
               next_q.rdata = cur;
               next_q.prev = cur;
               next_q.first = 1'b0;
               next_q.st = FSL_RREC;
               next_q.tmr = RREC;
               if (q.op == `FSL_OP_LOCKQ)
                  next_q.lock = cur[`FSL_BIT_LOCK];
            end
         end
         // recovery, then judge poll result
         FSL_RREC: begin
            if (q.tmr == 13'h0) begin
               next_q.st = FSL_IDLE;
               next_q.done = 1'b1;
               if (q.op == `FSL_OP_POLL) begin
                  next_q.done = 1'b0;
                  next_q.st = FSL_RACC;
                  next_q.tmr = ACC;
                  if (q.cfg) begin
                     // config 01: bit 7 high marks the end
                     if (q.rdata[`FSL_BIT_POLL]) begin
                        next_q.fail = q.rdata[`FSL_BIT_OPFAIL] |
                                      q.rdata[`FSL_BIT_SUPPLY];
                        next_q.opf = q.rdata[`FSL_BIT_OPFAIL];
                        next_q.vpp = q.rdata[`FSL_BIT_SUPPLY];
                        next_q.in_exit = 1'b1;
                        next_q.st = FSL_WSU;
                        next_q.tmr = WSU;
                     end
                  end else if (!q.first && q.err_seen &&
                               (q.rdata[`FSL_BIT_TOGGLE] != q.prev2_tgl)) begin
                     // still toggling after error showed: failed
                     next_q.fail = 1'b1;
                     next_q.opf = q.rdata[`FSL_BIT_OPFAIL];
                     next_q.vpp = q.rdata[`FSL_BIT_SUPPLY];
                     next_q.in_exit = 1'b1;
                     next_q.st = FSL_WSU;
                     next_q.tmr = WSU;
                  end else if (!q.first_pair && q.rdata[`FSL_BIT_TOGGLE] == q.prev2_tgl) begin
                     // toggle stopped: flash back in read mode
                     next_q.st = FSL_IDLE;
                     next_q.done = 1'b1;
                  end else if (!q.first_pair && (q.rdata[`FSL_BIT_OPFAIL] |
                                                 q.rdata[`FSL_BIT_SUPPLY])) begin
                     next_q.err_seen = 1'b1; // recheck once, bit 6 may lag
                  end
                  next_q.prev2_tgl = q.rdata[`FSL_BIT_TOGGLE];
                  next_q.first_pair = 1'b0;
               end
            end
         end
         FSL_WAIT: begin
            if (q.tmr == 13'h0) begin
               next_q.st = FSL_IDLE;
               next_q.done = 1'b1;
            end
         end
         FSL_RST: begin
            // flash reset clears locks but not its config
            next_q.rst_n = 1'b0;
            next_q.lock = 1'b0;
            if (q.tmr == 13'h0) begin
               next_q.rst_n = 1'b1;
               next_q.st = FSL_WAIT;
               next_q.tmr = RST;
            end
         end
      endcase
      if (q.st == FSL_IDLE)
         next_q.first_pair = 1'b1;
   end

   // state register, synchronous reset
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
         q.st <= FSL_IDLE;
         q.ce_n <= 1'b1;
         q.oe_n <= 1'b1;
         q.we_n <= 1'b1;
         q.rst_n <= 1'b1;
         q.first <= 1'b1;
         q.first_pair <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from the state flops
   assign pready = q.pready;
   assign prdata = q.prdata;
   assign pslverr = q.pslverr;
   assign fl_addr = q.fa;
   assign fl_dq_out = q.fd;
   assign fl_dq_oe = q.dq_oe;
   assign fl_ce_n = q.ce_n;
   assign fl_oe_n = q.oe_n;
   assign fl_we_n = q.we_n;
   assign fl_reset_n = q.rst_n;
endmodule : fsl_ctrl

/* File: fsl_ctrl_props.sv */
// concurrent checks on the apb side and flash pins of the controller
`timescale 1ns/1ps
module fsl_ctrl_props (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input logic pready,
   input logic pslverr,
   input logic [19:0] fl_addr,
   input logic fl_dq_oe,
   input logic fl_ce_n,
   input logic fl_oe_n,
   input logic fl_we_n,
   input logic fl_reset_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   property p_wr_qual;
      !fl_we_n |-> fl_oe_n && !fl_ce_n && fl_dq_oe;
   endproperty
   a_wr_qual: assert property (p_wr_qual) else $error("write strobe without qualifiers");
   property p_we_width;
      $fell(fl_we_n) |-> (!fl_we_n && $stable(fl_addr))[*8] ##1 fl_we_n;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write pulse length or address");
   property p_wr_setup;
      $fell(fl_we_n) |-> $past(!fl_ce_n && fl_dq_oe, 2);
   endproperty
   a_wr_setup: assert property (p_wr_setup) else $error("write setup too short");
   property p_rd_free;
      !fl_oe_n |-> !fl_dq_oe && fl_we_n;
   endproperty
   a_rd_free: assert property (p_rd_free) else $error("bus contention on read");
   property p_rd_width;
      $fell(fl_oe_n) |-> (!fl_oe_n && !fl_ce_n)[*8];
   endproperty
   a_rd_width: assert property (p_rd_width) else $error("read strobe too short");
   property p_ready_one;
      pready |=> !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
   property p_ready_time;
      psel && !penable |=> pready;
   endproperty
   a_ready_time: assert property (p_ready_time) else $error("apb answer late");
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
   property p_rst_pulse;
      $fell(fl_reset_n) |-> (!fl_reset_n && fl_we_n)[*8];
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("flash reset pulse short");
   property p_release;
      $fell(srst) |-> fl_ce_n && fl_we_n && fl_reset_n && !pready;
   endproperty
   a_release: assert property (p_release) else $error("pins busy after reset");
   c_write: cover property ($fell(fl_we_n));
   c_read: cover property ($fell(fl_oe_n));
   c_err: cover property (pslverr);
   c_rst: cover property ($fell(fl_reset_n));
endmodule : fsl_ctrl_props
bind fsl_ctrl fsl_ctrl_props fsl_ctrl_props_i (.clk, .srst, .psel, .penable, .pready,
   .pslverr, .fl_addr, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n);

/* File: fsl_flash_model.sv */
// behavioural flash partner: word program, status polling, faults
`timescale 1ns/1ps
module fsl_flash_model #(parameter int BUSY_READS = 3) (
   input wire logic [19:0] addr,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic mode01,
   input wire logic [1:0] fault,
   output logic [15:0] dq_in,
   output logic ready
);
   logic [15:0] mem [16]; // low address bits only
   logic [15:0] last = 16'h0000; // last word loaded
   logic [19:0] la = 20'h00000; // latched write address
   logic [15:0] q = 16'h0000; // read latch
   logic [1:0] err = 2'b00; // {supply fault, op fail}
   logic tgl = 1'b0;
   logic hold = 1'b0; // config 01: finished, stays in status until exit
   int busy = 0;
   // address at the later fall, which is we after ce
   always @(negedge we_n) if (!ce_n) la = addr;
   // data at the rise; a write while failed or held is the exit, other writes while busy are dropped
   always @(posedge we_n) begin
      if (!ce_n && reset_n) begin
         if (err != 2'b00 || hold) begin
            err = 2'b00;
            hold = 1'b0;
            busy = 0;
         end else if (busy == 0) begin
            mem[la[3:0]] = dq_out;
            last = dq_out;
            busy = BUSY_READS;
            err = fault;
         end
      end
   end
   // status while busy, failed or held, true data otherwise
   always @(negedge oe_n) begin
      #1; // address and chip select move on the same clock edge as oe
      if (!ce_n && (busy > 0 || err != 2'b00 || hold)) begin
         tgl = ~tgl;
         q = {8'h00, mode01 ? (busy == 0 || err != 2'b00) : ~last[7], tgl, err[0], 1'b0,
              err[1], 3'b000};
         if (err == 2'b00 && busy > 0) begin
            busy = busy - 1;
            hold = mode01 && busy == 0;
         end
      end else if (!ce_n) q = mem[addr[3:0]];
   end
   // reset pin aborts any operation
   always @(negedge reset_n) begin
      busy = 0;
      err = 2'b00;
      hold = 1'b0;
   end
   // released bus never shows a stale value
   assign dq_in = (!ce_n && !oe_n && !dq_oe) ? q : ~q;
   assign ready = (busy == 0);
endmodule : fsl_flash_model

/* File: fsl_pkg.sv */
// types for the flash status, lockdown and suspend controller
package fsl_pkg;
   // flash bus engine states
   typedef enum logic [2:0] {
      FSL_IDLE, FSL_WSU, FSL_WLOW, FSL_WHOLD, FSL_RACC, FSL_RREC, FSL_WAIT, FSL_RST
   } fsl_st_t;

   // whole module state
   typedef struct packed {
      fsl_st_t st;
      logic [3:0] op;
      logic [2:0] cnt;
      logic [2:0] idx;
      logic [12:0] tmr;
      logic [5:0][27:0] seq;
      logic [19:0] addr;
      logic [27:0] exitc;
      logic cfg;
      logic [15:0] rdata;
      logic [15:0] prev;
      logic first;
      logic err_seen;
      logic done;
      logic fail;
      logic vpp;
      logic opf;
      logic lock;
      logic in_exit;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [19:0] fa;
      logic [15:0] fd;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic rst_n;
      logic first_pair; // no toggle bit seen yet in this poll
      logic prev2_tgl; // toggle bit of the previous poll read
   } fsl_state_t;
endpackage : fsl_pkg
